//--- shared/dma_defines.svh
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH
// Descriptor word 0
`define SADDR 31:0
`define SOFF 47:32
`define SSIZE 50:48
`define DSIZE 58:56
// Descriptor word 1
`define NBYTES 31:0
`define SLAST 63:32
// Descriptor word 2
`define DADDR 31:0
`define DOFF 47:32
`define CITER 63:48
// Descriptor word 3
`define DLAST 31:0
`define BITER 47:32
`define INTMAJ 48
`define ESG 49
`define MELINK 50
`define MLINKCH 56:51
`define NELINK 57
`define NLINKCH 63:58
`define SGA_LOW 4:0
// Datapath and size codes
`define BUF_BYTES 32
`define SIZE_MAX 3'h2
`define SIZE_WORD 2'h2
`endif

//--- shared/dma_pkg.sv
package dma_pkg;
  typedef enum logic [2:0] {
    IDLE  = 3'b000,
    ARB   = 3'b001,
    FETCH = 3'b010,
    READ  = 3'b011,
    WRITE = 3'b100,
    WB    = 3'b101,
    SGR   = 3'b110,
    SGW   = 3'b111
  } state_t;
endpackage

//--- core/descriptor_dma_engine.sv
`timescale 1ns/1ns
`include "dma_defines.svh"

// What this block does
// - Two descriptor copies; new one loads spare
// - Preempt only after a read/write sequence
// - Channel runs to minor end unless preempted
// - Minor end writes saddr, daddr, citer back
// - Major end adjusts addresses, reloads citer, gathers
// - Datapath holds 32 bytes with alignment mux
// - Equal sizes alternate one read, one write
// - Unequal sizes: several small per large access
// - Engine wins memory; software access stalls
// - Single-port synchronous descriptor RAM, 64 wide
// - Arbitrate the cycle after a start flag
// - Winner number becomes RAM address, descriptor loaded
// - Read data held until destination write
// - Major end raises interrupt when enabled
// - First bus read starts during descriptor fetch
// - Minor link, then major interrupt, link, gather
// - Config errors record the channel number
// - Error seen again on next activation
// - Highest priority wins, lowest number on ties
// - Priority conflict blamed on selected channel
// - Start flag cleared when channel begins
// - Done set at major end, cleared on activation
// - Major link sets linked channel start flag
// - Misaligned gather pointer is a config error
module descriptor_dma_engine #(
  parameter int NCH = 4,
  parameter int PW = 4,
  localparam int CW = $clog2(NCH),
  localparam int AW = CW + 2
) (
  input wire logic core_clk_i, // 250 MHz clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [NCH-1:0] start_set_i, // software start pulses
  input wire logic [NCH-1:0] done_clr_i, // software done clears
  input wire logic [NCH-1:0] irq_clr_i, // interrupt clears
  input wire logic error_clr_i, // clears error status
  input wire logic [NCH*PW-1:0] channel_priority_i, // per channel
  input wire logic [NCH-1:0] preempt_enable_i, // may be preempted
  input wire logic [NCH-1:0] error_interrupt_enable_i, // error irq en
  input wire logic round_robin_i, // 1: round robin
  input wire logic sw_req_i, // software RAM request
  input wire logic sw_we_i, // software write
  input wire logic [AW-1:0] sw_addr_i, // channel and word
  input wire logic [63:0] sw_wdata_i, // write word
  output logic sw_ack_o, // request done
  output logic [63:0] sw_rdata_o, // read word
  output logic bus_req_o, // system_bus request
  output logic bus_we_o, // write access
  output logic [31:0] bus_addr_o, // byte address
  output logic [1:0] bus_size_o, // 0 byte, 1 half, 2 word
  output logic [31:0] bus_wdata_o, // right justified
  input wire logic bus_ack_i, // access complete
  input wire logic [31:0] bus_rdata_i, // right justified
  output logic [NCH-1:0] start_o, // start flags
  output logic [NCH-1:0] active_o, // active flags
  output logic [NCH-1:0] done_o, // done flags
  output logic [NCH-1:0] interrupt_request_o, // major end irqs
  output logic [NCH-1:0] error_irq_o, // error irqs
  output logic err_valid_o, // config error seen
  output logic err_prio_o, // priority conflict seen
  output logic [CW-1:0] err_channel_o // failing channel
);
  logic rst_sync_reg, rst_n;
  dma_pkg::state_t state_reg;
  logic [2:0] cnt_reg;
  logic cur_reg, held_reg, maj_reg;
  logic [63:0] mem [NCH*4];
  logic [63:0] desc_reg [2][4];
  logic [31:0] left_reg [2];
  logic [CW-1:0] ch_reg [2];
  logic [`BUF_BYTES*8-1:0] buf_reg;
  logic [5:0] fill_reg;
  logic [NCH-1:0] start_reg, link_set;
  logic rr_reg;
  logic [CW-1:0] last_reg, win, idx, ach;
  logic found, dup, higher;
  logic [63:0] w0, w1, w2, w3, m_d;
  logic [5:0] sb, db, rsb;
  logic [31:0] rd_m;
  logic rd_ack, wr_ack, more_wr, to_wr, cfg_err, minor_end, major_end;
  logic sg_go, sga_err, retire, eng_en, sw_go, m_en, m_we;
  logic [AW-1:0] m_a;

  function automatic logic [5:0] size_bytes(input logic [2:0] s);
    case (s)
      3'h0: size_bytes = 6'h01;
      3'h1: size_bytes = 6'h02;
      default: size_bytes = 6'h04;
    endcase
  endfunction

  function automatic logic [31:0] sext(input logic [15:0] v);
    sext = {{16{v[15]}}, v};
  endfunction

  // Reset released through two flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync_reg <= 1'b1;
      rst_n <= rst_sync_reg;
    end
  end

  // Active slot view
  assign ach = ch_reg[cur_reg];
  assign w0 = desc_reg[cur_reg][0];
  assign w1 = desc_reg[cur_reg][1];
  assign w2 = desc_reg[cur_reg][2];
  assign w3 = desc_reg[cur_reg][3];
  assign sb = size_bytes(w0[`SSIZE]);
  assign db = size_bytes(w0[`DSIZE]);
  assign rsb = (state_reg == dma_pkg::SGR) ? 6'h04 : sb;
  assign rd_m = bus_rdata_i & ((rsb == 6'h01) ? 32'h0000_00FF :
                (rsb == 6'h02) ? 32'h0000_FFFF : 32'hFFFF_FFFF);
  assign rd_ack = bus_ack_i && bus_req_o && !bus_we_o;
  assign wr_ack = bus_ack_i && bus_req_o && bus_we_o;
  // Another write is due while the buffer holds at least two full units
  assign more_wr = {1'b0, fill_reg} >= {db, 1'b0};
  assign to_wr = {1'b0, fill_reg} + {1'b0, rsb} >= {1'b0, db};
  assign minor_end = wr_ack && !more_wr && left_reg[cur_reg] == 32'h0;
  assign major_end = minor_end && w2[`CITER] == 16'h0001;
  // Size codes and byte count checked once words 0 and 1 are in
  assign cfg_err = w0[`SSIZE] > `SIZE_MAX || w0[`DSIZE] > `SIZE_MAX ||
                   w1[`NBYTES] == 32'h0 ||
                   (w1[5:0] & ((sb > db ? sb : db) - 6'h01)) != 6'h00;
  assign sg_go = maj_reg && w3[`ESG] && w3[`SGA_LOW] == 5'h00;
  assign sga_err = state_reg == dma_pkg::WB && cnt_reg == 3'h1 &&
                   maj_reg && w3[`ESG] && w3[`SGA_LOW] != 5'h00;
  assign retire = (state_reg == dma_pkg::FETCH && cnt_reg == 3'h3 &&
                   cfg_err) || (state_reg == dma_pkg::WB &&
                   cnt_reg == 3'h1 && !sg_go) ||
                  (state_reg == dma_pkg::SGW && cnt_reg == 3'h3);

  // Arbitration; descending scan keeps the lowest number on ties
  always_comb begin
    win = '0;
    idx = '0;
    found = 1'b0;
    dup = 1'b0;
    if (rr_reg) begin
      for (int k = NCH; k >= 1; k--) begin
        idx = CW'((int'(last_reg) + k) % NCH);
        if (start_reg[idx]) begin
          win = idx;
          found = 1'b1;
        end
      end
    end else begin
      for (int i = NCH - 1; i >= 0; i--) begin
        if (start_reg[i] && (!found || channel_priority_i[i*PW +: PW] >=
            channel_priority_i[win*PW +: PW])) begin
          win = CW'(i);
          found = 1'b1;
        end
      end
    end
    for (int i = 0; i < NCH; i++) begin
      for (int j = i + 1; j < NCH; j++) begin
        if (channel_priority_i[i*PW +: PW] == channel_priority_i[j*PW +: PW])
          dup = 1'b1;
      end
    end
    higher = found && channel_priority_i[win*PW +: PW] >
             channel_priority_i[ach*PW +: PW];
  end

  // Link targets, ignored when out of range
  always_comb begin
    link_set = '0;
    for (int i = 0; i < NCH; i++) begin
      if (state_reg == dma_pkg::WB && cnt_reg == 3'h1) begin
        if (!maj_reg && w3[`NELINK] && w3[`NLINKCH] == 6'(i))
          link_set[i] = 1'b1;
        if (maj_reg && w3[`MELINK] && w3[`MLINKCH] == 6'(i))
          link_set[i] = 1'b1;
      end
    end
  end

  // Memory port mux; engine always has the port when it needs it
  always_comb begin
    eng_en = state_reg == dma_pkg::FETCH || state_reg == dma_pkg::WB ||
             state_reg == dma_pkg::SGW;
    m_a = {ach, cnt_reg[1:0]};
    m_d = buf_reg[{cnt_reg[1:0], 6'h00} +: 64];
    if (state_reg == dma_pkg::WB) begin
      m_a = {ach, cnt_reg[0], 1'b0};
      m_d = cnt_reg[0] ? w2 : w0;
    end
    sw_go = sw_req_i && !sw_ack_o && !eng_en;
    m_en = eng_en || sw_go;
    m_we = eng_en ? state_reg != dma_pkg::FETCH : sw_we_i;
    if (!eng_en) begin
      m_a = sw_addr_i;
      m_d = sw_wdata_i;
    end
  end

  // Single-port RAM array, no reset on contents
  always_ff @(posedge core_clk_i) begin
    if (m_en && m_we)
      mem[m_a] <= m_d;
  end

  // Registered RAM read port, also the software read data
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sw_rdata_o <= '0;
      sw_ack_o <= 1'b0;
    end else begin
      if (m_en && !m_we)
        sw_rdata_o <= mem[m_a];
      sw_ack_o <= sw_go;
    end
  end

  // Sequencer
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dma_pkg::IDLE;
      cnt_reg <= 3'h0;
      cur_reg <= 1'b0;
      held_reg <= 1'b0;
      maj_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        dma_pkg::IDLE: if (|start_reg) state_reg <= dma_pkg::ARB;
        dma_pkg::ARB: begin
          state_reg <= dma_pkg::FETCH;
          cnt_reg <= 3'h0;
          cur_reg <= ~cur_reg;
        end
        dma_pkg::FETCH: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h3)
            state_reg <= cfg_err ? dma_pkg::IDLE : dma_pkg::READ;
        end
        dma_pkg::READ: begin
          if (cnt_reg == 3'h4)
            cnt_reg <= 3'h5;
          if (rd_ack && to_wr)
            state_reg <= dma_pkg::WRITE;
        end
        dma_pkg::WRITE: begin
          if (wr_ack) begin
            if (more_wr)
              state_reg <= dma_pkg::WRITE;
            else if (minor_end) begin
              state_reg <= dma_pkg::WB;
              cnt_reg <= 3'h0;
              maj_reg <= major_end;
            end else if (preempt_enable_i[ach] && !held_reg && higher) begin
              state_reg <= dma_pkg::ARB;
              held_reg <= 1'b1;
            end else
              state_reg <= dma_pkg::READ;
          end
        end
        dma_pkg::WB: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h1 && sg_go) begin
            state_reg <= dma_pkg::SGR;
            cnt_reg <= 3'h0;
          end
        end
        dma_pkg::SGR: begin
          if (rd_ack) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h7)
              state_reg <= dma_pkg::SGW;
          end
        end
        dma_pkg::SGW: cnt_reg <= cnt_reg + 3'h1;
      endcase
      // A preempted channel resumes from its own slot
      if (retire) begin
        state_reg <= held_reg ? dma_pkg::READ : dma_pkg::IDLE;
        cur_reg <= held_reg ? ~cur_reg : cur_reg;
        cnt_reg <= 3'h5;
        held_reg <= 1'b0;
      end
    end
  end

  // Descriptor copies and working addresses
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < 2; s++) begin
        for (int w = 0; w < 4; w++)
          desc_reg[s][w] <= '0;
        left_reg[s] <= '0;
        ch_reg[s] <= '0;
      end
    end else begin
      if (state_reg == dma_pkg::ARB)
        ch_reg[~cur_reg] <= win;
      if (state_reg == dma_pkg::FETCH && cnt_reg != 3'h0)
        desc_reg[cur_reg][2'(cnt_reg - 3'h1)] <= sw_rdata_o;
      if (state_reg == dma_pkg::FETCH && cnt_reg == 3'h2)
        left_reg[cur_reg] <= sw_rdata_o[`NBYTES];
      // Last word lands while the first read is under way
      if (state_reg == dma_pkg::READ && cnt_reg == 3'h4)
        desc_reg[cur_reg][3] <= sw_rdata_o;
      if (rd_ack && state_reg == dma_pkg::READ) begin
        desc_reg[cur_reg][0][`SADDR] <= w0[`SADDR] + sext(w0[`SOFF]);
        left_reg[cur_reg] <= left_reg[cur_reg] - 32'(sb);
      end
      if (wr_ack) begin
        desc_reg[cur_reg][2][`DADDR] <= w2[`DADDR] + sext(w2[`DOFF]) +
          ((major_end && !w3[`ESG]) ? w3[`DLAST] : 32'h0);
        if (minor_end)
          desc_reg[cur_reg][2][`CITER] <= major_end ? w3[`BITER] :
                                          w2[`CITER] - 16'h0001;
        // Last read already stepped saddr; only the final adjustment
        if (major_end)
          desc_reg[cur_reg][0][`SADDR] <= w0[`SADDR] + w1[`SLAST];
      end
    end
  end

  // Byte buffer: reads append at the fill point, writes drain the bottom
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg <= '0;
      fill_reg <= 6'h00;
    end else if (state_reg == dma_pkg::SGW && cnt_reg == 3'h3) begin
      buf_reg <= '0;
      fill_reg <= 6'h00;
    end else if (rd_ack) begin
      buf_reg <= buf_reg | ({224'h0, rd_m} << {fill_reg, 3'b000});
      fill_reg <= fill_reg + rsb;
    end else if (wr_ack) begin
      buf_reg <= buf_reg >> {db, 3'b000};
      fill_reg <= fill_reg - db;
    end
  end

  // Bus master; one idle cycle between accesses
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_req_o <= 1'b0;
      bus_we_o <= 1'b0;
      bus_addr_o <= '0;
      bus_size_o <= 2'h0;
      bus_wdata_o <= '0;
    end else if (bus_ack_i && bus_req_o)
      bus_req_o <= 1'b0;
    else if (!bus_req_o) begin
      if ((state_reg == dma_pkg::FETCH && cnt_reg == 3'h3 && !cfg_err) ||
          state_reg == dma_pkg::READ) begin
        bus_req_o <= 1'b1;
        bus_we_o <= 1'b0;
        bus_addr_o <= w0[`SADDR];
        bus_size_o <= w0[49:48];
      end else if (state_reg == dma_pkg::WRITE) begin
        bus_req_o <= 1'b1;
        bus_we_o <= 1'b1;
        bus_addr_o <= w2[`DADDR];
        bus_size_o <= w0[57:56];
        bus_wdata_o <= buf_reg[31:0];
      end else if (state_reg == dma_pkg::SGR) begin
        bus_req_o <= 1'b1;
        bus_we_o <= 1'b0;
        bus_addr_o <= w3[`DLAST] + {27'h0, cnt_reg, 2'b00};
        bus_size_o <= `SIZE_WORD;
      end
    end
  end

  // Channel flags; a hardware set beats a same-cycle clear
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= '0;
      active_o <= '0;
      done_o <= '0;
      interrupt_request_o <= '0;
    end else begin
      start_reg <= (start_reg & ~((state_reg == dma_pkg::ARB) ?
                   NCH'(1) << win : '0)) | start_set_i | link_set;
      // Software clears are honoured in the arbitration cycle as well
      done_o <= done_o & ~done_clr_i;
      if (state_reg == dma_pkg::ARB) begin
        active_o[win] <= 1'b1;
        done_o[win] <= 1'b0;
      end
      if (state_reg == dma_pkg::WB && cnt_reg == 3'h1 && maj_reg)
        done_o[ach] <= 1'b1;
      if (retire || sga_err)
        active_o[ach] <= 1'b0;
      interrupt_request_o <= interrupt_request_o & ~irq_clr_i;
      if (state_reg == dma_pkg::WB && cnt_reg == 3'h1 && maj_reg &&
          w3[`INTMAJ])
        interrupt_request_o[ach] <= 1'b1;
    end
  end

  // Error status and arbitration mode
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      err_valid_o <= 1'b0;
      err_prio_o <= 1'b0;
      err_channel_o <= '0;
      error_irq_o <= '0;
      rr_reg <= 1'b0;
      last_reg <= '0;
    end else begin
      rr_reg <= round_robin_i;
      if (error_clr_i) begin
        err_valid_o <= 1'b0;
        err_prio_o <= 1'b0;
        error_irq_o <= '0;
      end
      if (state_reg == dma_pkg::ARB) begin
        last_reg <= win;
        if (dup) begin
          err_prio_o <= 1'b1;
          error_irq_o[win] <= error_interrupt_enable_i[win];
        end
      end
      if ((state_reg == dma_pkg::FETCH && cnt_reg == 3'h3 && cfg_err) ||
          sga_err) begin
        err_valid_o <= 1'b1;
        err_channel_o <= ach;
        error_irq_o[ach] <= error_interrupt_enable_i[ach];
      end
    end
  end

  assign start_o = start_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  a_arb_next: assert property (
    (state_reg == dma_pkg::IDLE && |start_reg) |=> state_reg == dma_pkg::ARB)
    else $error("arbitration not one cycle after start");
  a_fetch_four: assert property (
    state_reg == dma_pkg::ARB |=> state_reg == dma_pkg::FETCH [*4])
    else $error("descriptor fetch not four cycles");
  a_engine_wins: assert property (
    (eng_en && sw_req_i && !sw_ack_o) |=> !sw_ack_o)
    else $error("software access not stalled");
  a_early_read: assert property (
    (state_reg == dma_pkg::FETCH && cnt_reg == 3'h3 && !cfg_err) |=>
    bus_req_o && !bus_we_o && state_reg == dma_pkg::READ)
    else $error("first read not started during fetch");
  a_cfg_block: assert property (
    (state_reg == dma_pkg::FETCH && cnt_reg == 3'h3 && cfg_err) |=>
    !active_o[$past(ach)] && err_valid_o && err_channel_o == $past(ach))
    else $error("config error not blocked or recorded");
  a_minor_wb: assert property (
    minor_end |=> state_reg == dma_pkg::WB [*2])
    else $error("minor end without write-back");
  a_citer_reload: assert property (
    major_end |=> w2[`CITER] == $past(w3[`BITER]))
    else $error("citer not reloaded at major end");
  a_major_done: assert property (
    major_end |-> ##3 done_o[$past(ach, 3)])
    else $error("done not set after major end");
  a_equal_alt: assert property (
    (rd_ack && state_reg == dma_pkg::READ && w0[`SSIZE] == w0[`DSIZE]) |=>
    state_reg == dma_pkg::WRITE)
    else $error("equal sizes did not alternate");
  a_write_full: assert property (
    (bus_req_o && bus_we_o) |-> fill_reg >= db)
    else $error("write issued without held data");

  c_major: cover property (major_end);
  c_preempt: cover property (state_reg == dma_pkg::WRITE ##1
                             state_reg == dma_pkg::ARB);
  c_gather: cover property (state_reg == dma_pkg::SGW);
  c_cfg_err: cover property (sga_err);
endmodule

//--- dv/bus_slave_model.sv
`timescale 1ns/1ns
// System bus slave: pattern memory, random wait states
module bus_slave_model (
  input wire logic core_clk_i, // clock
  input wire logic req_i, // access request
  input wire logic [31:0] addr_i, // byte address
  input wire logic [1:0] size_i, // 0 byte, 1 half, 2 word
  output logic ack_o = 1'b0, // one-cycle completion
  output logic [31:0] rdata_o = 32'h0 // right-justified read data
);
  logic [1:0] wait_reg = 2'h0;

  // Byte pattern that differs per address, so misplaced lanes show
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  function automatic logic [31:0] rd_word(input logic [31:0] a,
                                          input logic [1:0] s);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < (1 << s); i++) begin
      v[8*i+:8] = mem_byte(a + 32'(i));
    end
    return v;
  endfunction

  // Data toggles outside ack so a stale capture never matches
  always @(posedge core_clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      if (wait_reg == 2'h0) begin
        ack_o <= 1'b1;
        rdata_o <= rd_word(addr_i, size_i);
        wait_reg <= 2'($urandom % 3);
      end else begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
endmodule

//--- dv/tb_descriptor_dma_engine.sv
`timescale 1ns/1ns
`include "dma_defines.svh"
module tb_descriptor_dma_engine;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] start_set_i = 4'h0, done_clr_i = 4'h0, irq_clr_i = 4'h0;
  logic [3:0] preempt_enable_i = 4'h0, error_interrupt_enable_i = 4'h0;
  logic error_clr_i = 1'b0, round_robin_i = 1'b0;
  logic sw_req_i = 1'b0, sw_we_i = 1'b0;
  logic [15:0] channel_priority_i = 16'h3210;
  logic [3:0] sw_addr_i = 4'h0;
  logic [63:0] sw_wdata_i = 64'h0, sw_rdata_o, rword;
  logic sw_ack_o, bus_req_o, bus_we_o, bus_ack_i, err_valid_o, err_prio_o;
  logic [31:0] bus_addr_o, bus_wdata_o, bus_rdata_i;
  logic [1:0] bus_size_o, err_channel_o;
  logic [3:0] start_o, active_o, done_o, interrupt_request_o, error_irq_o;
  logic [66:0] exp_q[$];
  logic [66:0] e;
  logic [31:0] sa[4];
  int fails = 0;
  int checks = 0;

  descriptor_dma_engine #(.NCH(4), .PW(4)) u_descriptor_dma_engine (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_set_i(start_set_i),
    .done_clr_i(done_clr_i), .irq_clr_i(irq_clr_i),
    .error_clr_i(error_clr_i), .channel_priority_i(channel_priority_i),
    .preempt_enable_i(preempt_enable_i),
    .error_interrupt_enable_i(error_interrupt_enable_i),
    .round_robin_i(round_robin_i), .sw_req_i(sw_req_i), .sw_we_i(sw_we_i),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_ack_o(sw_ack_o),
    .sw_rdata_o(sw_rdata_o), .bus_req_o(bus_req_o), .bus_we_o(bus_we_o),
    .bus_addr_o(bus_addr_o), .bus_size_o(bus_size_o),
    .bus_wdata_o(bus_wdata_o), .bus_ack_i(bus_ack_i),
    .bus_rdata_i(bus_rdata_i), .start_o(start_o), .active_o(active_o),
    .done_o(done_o), .interrupt_request_o(interrupt_request_o),
    .error_irq_o(error_irq_o), .err_valid_o(err_valid_o),
    .err_prio_o(err_prio_o), .err_channel_o(err_channel_o));

  bus_slave_model u_bus_slave_model (
    .core_clk_i(core_clk_i), .req_i(bus_req_o), .addr_i(bus_addr_o),
    .size_i(bus_size_o), .ack_o(bus_ack_i), .rdata_o(bus_rdata_i));

  always #2 core_clk_i = ~core_clk_i;

  task check(input string what, input logic [66:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Every completed bus access must be the oldest planned one
  always @(posedge core_clk_i) begin
    if (bus_req_o === 1'b1 && bus_ack_i === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unplanned access", 67'h1, 67'h0);
      end else begin
        e = exp_q.pop_front();
        check("bus access", {bus_we_o, bus_size_o, bus_addr_o,
          bus_we_o ? bus_wdata_o : 32'h0}, e);
      end
    end
  end

  // Descriptor memory access; holds the request until acknowledged
  task ram(input logic we, input logic [3:0] a, input logic [63:0] d);
    @(negedge core_clk_i);
    sw_req_i = 1'b1;
    sw_we_i = we;
    sw_addr_i = a;
    sw_wdata_i = d;
    for (int i = 0; i < 100 && sw_ack_o !== 1'b1; i++)
      @(negedge core_clk_i);
    rword = sw_rdata_o;
    sw_req_i = 1'b0;
    check("ram ack", sw_ack_o, 1);
  endtask

  // Word three goes last, after the rest is in place
  task set_desc(input int c, input logic [31:0] s, input int ss, nb,
                input logic [31:0] d, input int cnt);
    logic [63:0] w;
    w = 64'h0;
    w[`SADDR] = s;
    w[`SOFF] = 16'(1 << ss);
    w[`SSIZE] = 3'(ss);
    w[`DSIZE] = 3'h2;
    ram(1'b1, 4'(c * 4), w);
    w = 64'h0;
    w[`NBYTES] = 32'(nb);
    w[`SLAST] = 32'(-nb * cnt);
    ram(1'b1, 4'(c * 4 + 1), w);
    w = 64'h0;
    w[`DADDR] = d;
    w[`DOFF] = 16'h0004;
    w[`CITER] = 16'(cnt);
    ram(1'b1, 4'(c * 4 + 2), w);
    w = 64'h0;
    w[`DLAST] = 32'(-nb * cnt);
    w[`BITER] = 16'(cnt);
    w[`INTMAJ] = 1'b1;
    ram(1'b1, 4'(c * 4 + 3), w);
  endtask

  // Small reads per word write, lanes assembled little-endian
  task plan(input logic [31:0] s, d, input int ss, nb);
    logic [31:0] w;
    for (int k = 0; k < nb / 4; k++) begin
      for (int r = 0; r < (4 >> ss); r++)
        exp_q.push_back({1'b0, 2'(ss), 32'(s + k * 4 + r * (1 << ss)),
          32'h0});
      for (int b = 0; b < 4; b++)
        w[8*b+:8] = u_bus_slave_model.mem_byte(32'(s + 4 * k + b));
      exp_q.push_back({1'b1, 2'h2, 32'(d + 4 * k), w});
    end
  endtask

  task start_wait(input logic [3:0] m);
    @(negedge core_clk_i);
    start_set_i = m;
    @(negedge core_clk_i);
    start_set_i = 4'h0;
    check("start flags", start_o, m);
    for (int i = 0; i < 1000 && (start_o | active_o) !== 4'h0; i++)
      @(negedge core_clk_i);
    check("idle flags", start_o | active_o, 0);
  endtask

  initial begin
    void'($urandom(65692));
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    check("reset outputs", {start_o, done_o, error_irq_o, err_valid_o}, 0);
    // Byte, half and word sources into word writes, two minors each
    for (int c = 0; c < 3; c++) begin
      sa[c] = $urandom & 32'h0FFF_FFFC;
      set_desc(c, sa[c], c, 16, 32'h2000 + c * 32'h100, 2);
      plan(sa[c], 32'h2000 + c * 32'h100, c, 16);
      // Software read lands in the fetch and must wait for it
      fork
        start_wait(4'h1 << c);
        begin
          repeat (3) @(negedge core_clk_i);
          ram(1'b0, 4'(c * 4 + 1), 64'h0);
        end
      join
      check("stalled read", rword[`NBYTES], 16);
      check("done after minor", done_o[c], 0);
      ram(1'b0, 4'(c * 4), 64'h0);
      check("saddr written back", rword[`SADDR], sa[c] + 16);
      ram(1'b0, 4'(c * 4 + 2), 64'h0);
      check("daddr citer", {rword[`DADDR], rword[`CITER]},
        {32'h2010 + c * 32'h100, 16'h1});
      plan(sa[c] + 16, 32'h2010 + c * 32'h100, c, 16);
      start_wait(4'h1 << c);
      check("done and irq", {done_o[c], interrupt_request_o[c]}, 3);
      ram(1'b0, 4'(c * 4), 64'h0);
      check("saddr adjusted", rword[`SADDR], sa[c]);
      ram(1'b0, 4'(c * 4 + 2), 64'h0);
      check("citer reloaded", {rword[`DADDR], rword[`CITER]},
        {32'h2000 + c * 32'h100, 16'h2});
    end
    check("accesses left", exp_q.size(), 0);
    @(negedge core_clk_i);
    done_clr_i = 4'hF;
    irq_clr_i = 4'hF;
    @(negedge core_clk_i);
    done_clr_i = 4'h0;
    irq_clr_i = 4'h0;
    @(negedge core_clk_i);
    check("cleared flags", {done_o, interrupt_request_o}, 0);
    // Tie between channels 1 and 2: lower number runs first
    channel_priority_i = 16'h1771;
    error_interrupt_enable_i = 4'hF;
    plan(sa[1], 32'h2100, 1, 16);
    plan(sa[2], 32'h2200, 2, 16);
    start_wait(4'h6);
    check("priority error", {err_prio_o, error_irq_o[1]}, 3);
    check("accesses left", exp_q.size(), 0);
    @(negedge core_clk_i);
    error_clr_i = 1'b1;
    channel_priority_i = 16'h3210;
    @(negedge core_clk_i);
    error_clr_i = 1'b0;
    // Zero byte count refused on every activation
    set_desc(3, 32'h0100, 0, 0, 32'h3000, 1);
    for (int rep = 0; rep < 2; rep++) begin
      start_wait(4'h8);
      check("config error", {err_valid_o, err_channel_o, error_irq_o[3]},
        {1'b1, 2'h3, 1'b1});
      @(negedge core_clk_i);
      error_clr_i = 1'b1;
      @(negedge core_clk_i);
      error_clr_i = 1'b0;
      @(negedge core_clk_i);
      check("error cleared", err_valid_o, 0);
    end
    // Round robin after channel 3: channel 0 before higher channel 1
    round_robin_i = 1'b1;
    plan(sa[0], 32'h2000, 0, 16);
    plan(sa[1] + 16, 32'h2110, 1, 16);
    start_wait(4'h3);
    check("accesses left", exp_q.size(), 0);
    final_report;
  end

  // Watchdog far beyond the expected run of under a thousand cycles
  initial begin
    #200000;
    fails++;
    final_report;
  end
endmodule
